// ==== crb_dev_end.sv ====
// What this block does
// - Main result 32-bit, sent bit 31 first
// - Zero main input gives all-zero word
// - Results clip at two's-complement extremes
// - Aux result 24-bit, sent bit 23 first
// - Zero aux input gives all-zero word
// - Host may truncate main result to 24
// - Integrity byte last, only when enabled
// - No integrity byte on register read-back
// - Integrity covers four or three data bytes
// - Sum mode: byte sum plus 9Bh
// - Host checks integrity, rereads on mismatch
// - CRC mode: polynomial x8+x2+x+1
// - CRC over data padded by eight zeros
// - Conversion clock nominal 7.3728 MHz
// - Auto-select external clock when active
// - Status bit 5 shows clock source
// - Internal oscillator runs from power-on
// - External clock must be glitch-free
// - New-data flags per converter since read
`timescale 1ns/1ps
module crb_dev_end (
    input wire logic clk_i, // 10 MHz clock
    input wire logic nrst_i, // Sync reset, active low
    crb_link_if.dev link, // Serial read-back link
    input wire logic [33:0] main_raw_i, // Main filter output, wide signed
    input wire logic main_done_i, // Main conversion done pulse
    input wire logic [25:0] aux_raw_i, // Aux filter output, wide signed
    input wire logic aux_done_i, // Aux conversion done pulse
    input wire logic [7:0] reg_byte_i, // Register byte for read-back
    input wire logic clock_input_pin_i, // External clock pin
    output logic osc_en_o, // Internal oscillator enable
    output logic conv_clk_ext_o, // Conversion clock from external pin
    output logic [31:0] main_result_o, // Latest main word
    output logic [23:0] aux_result_o // Latest aux word
);
    typedef enum logic [1:0] {
        CRB_IDLE = 2'b01,
        CRB_SHIFT = 2'b10
    } crb_dev_state_t;

    logic [31:0] main_word_ff;
    logic [31:0] nxt_main_word;
    logic [23:0] aux_word_ff;
    logic [23:0] nxt_aux_word;
    logic main_new_ff;
    logic nxt_main_new;
    logic aux_new_ff;
    logic nxt_aux_new;
    logic [2:0] sync_ff;
    logic [2:0] nxt_sync;
    logic [7:0] win_cnt_ff;
    logic [7:0] nxt_win_cnt;
    logic ext_ff;
    logic nxt_ext;
    crb_dev_state_t st_ff;
    crb_dev_state_t nxt_st;
    logic [39:0] sh_ff;
    logic [39:0] nxt_sh;
    logic [5:0] cnt_ff;
    logic [5:0] nxt_cnt;
    logic sdata_ff;
    logic nxt_sdata;
    logic vld_ff;
    logic nxt_vld;
    logic last_ff;
    logic nxt_last;
    logic [7:0] stat_ff;
    logic [7:0] nxt_stat;
    logic clk_edge;
    logic start;
    logic with_chk;

    // Results: clip wide filter output, keep new-data flags
    always_comb
    begin
        nxt_main_word = main_word_ff;
        nxt_aux_word = aux_word_ff;
        nxt_main_new = main_new_ff;
        nxt_aux_new = aux_new_ff;
        // Flag clears when a read of that converter starts
        if (start && link.rd_kind == crb_pkg::KIND_MAIN)
        begin
            nxt_main_new = 1'b0;
        end
        if (start && link.rd_kind == crb_pkg::KIND_AUX)
        begin
            nxt_aux_new = 1'b0;
        end
        // A fresh result in the same cycle wins over the clear
        if (main_done_i)
        begin
            nxt_main_new = 1'b1;
            if (main_raw_i[33:31] == 3'h0 || main_raw_i[33:31] == 3'h7)
            begin
                nxt_main_word = main_raw_i[31:0];
            end
            else
            begin
                nxt_main_word = main_raw_i[33] ? crb_pkg::MAIN_MIN : crb_pkg::MAIN_MAX;
            end
        end
        if (aux_done_i)
        begin
            nxt_aux_new = 1'b1;
            if (aux_raw_i[25:23] == 3'h0 || aux_raw_i[25:23] == 3'h7)
            begin
                nxt_aux_word = aux_raw_i[23:0];
            end
            else
            begin
                nxt_aux_word = aux_raw_i[25] ? crb_pkg::AUX_MIN : crb_pkg::AUX_MAX;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            main_word_ff <= 32'h00000000;
            aux_word_ff <= 24'h000000;
            main_new_ff <= 1'b0;
            aux_new_ff <= 1'b0;
        end
        else
        begin
            main_word_ff <= nxt_main_word;
            aux_word_ff <= nxt_aux_word;
            main_new_ff <= nxt_main_new;
            aux_new_ff <= nxt_aux_new;
        end
    end

    // Clock detect: three-stage sync, edges seen only on stages two and three
    // A pin silent for a whole window falls back to the internal oscillator;
    // sampling at 10 MHz aliases a 7.3728 MHz clock but still shows edges
    assign clk_edge = sync_ff[1] ^ sync_ff[2];

    always_comb
    begin
        nxt_sync = {sync_ff[1:0], clock_input_pin_i};
        nxt_win_cnt = win_cnt_ff;
        nxt_ext = ext_ff;
        if (clk_edge)
        begin
            nxt_win_cnt = crb_pkg::DET_WIN_CYC;
            nxt_ext = 1'b1;
        end
        else if (win_cnt_ff != 8'h00)
        begin
            nxt_win_cnt = win_cnt_ff - 8'h01;
        end
        else
        begin
            nxt_ext = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            sync_ff <= 3'h0;
            win_cnt_ff <= 8'h00;
            ext_ff <= 1'b0;
        end
        else
        begin
            sync_ff <= nxt_sync;
            win_cnt_ff <= nxt_win_cnt;
            ext_ff <= nxt_ext;
        end
    end

    // Frame shifter: data MSB first, then the optional integrity byte
    assign start = (st_ff == CRB_IDLE) && link.rd_req;
    assign with_chk = (link.chk_mode != crb_pkg::MODE_OFF) &&
                      (link.rd_kind != crb_pkg::KIND_REG);

    always_comb
    begin
        nxt_st = st_ff;
        nxt_sh = sh_ff;
        nxt_cnt = cnt_ff;
        nxt_sdata = 1'b0;
        nxt_vld = 1'b0;
        nxt_last = 1'b0;
        nxt_stat = 8'h00;
        nxt_stat[crb_pkg::STAT_AUX_NEW] = aux_new_ff;
        nxt_stat[crb_pkg::STAT_MAIN_NEW] = main_new_ff;
        nxt_stat[crb_pkg::STAT_CLK_SRC] = ext_ff;
        unique case (st_ff)
            CRB_IDLE:
            begin
                if (link.rd_req)
                begin
                    nxt_st = CRB_SHIFT;
                    unique case (link.rd_kind)
                        crb_pkg::KIND_AUX:
                        begin
                            nxt_sh = {aux_word_ff, crb_pkg::check_byte({8'h00, aux_word_ff},
                                      1'b1, link.chk_mode), 8'h00};
                            nxt_cnt = crb_pkg::AUX_BITS;
                        end
                        crb_pkg::KIND_REG:
                        begin
                            nxt_sh = {reg_byte_i, 32'h00000000};
                            nxt_cnt = crb_pkg::REG_BITS;
                        end
                        default:
                        begin
                            nxt_sh = {main_word_ff, crb_pkg::check_byte(main_word_ff,
                                      1'b0, link.chk_mode)};
                            nxt_cnt = crb_pkg::MAIN_BITS;
                        end
                    endcase
                    if (with_chk)
                    begin
                        nxt_cnt = 6'(nxt_cnt + crb_pkg::CHK_BITS);
                    end
                end
            end
            CRB_SHIFT:
            begin
                nxt_sdata = sh_ff[39];
                nxt_vld = 1'b1;
                nxt_last = (cnt_ff == 6'h01);
                nxt_sh = {sh_ff[38:0], 1'b0};
                nxt_cnt = cnt_ff - 6'h01;
                if (cnt_ff == 6'h01)
                begin
                    nxt_st = CRB_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            st_ff <= CRB_IDLE;
            sh_ff <= 40'h0000000000;
            cnt_ff <= 6'h00;
            sdata_ff <= 1'b0;
            vld_ff <= 1'b0;
            last_ff <= 1'b0;
            stat_ff <= 8'h00;
        end
        else
        begin
            st_ff <= nxt_st;
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
            sdata_ff <= nxt_sdata;
            vld_ff <= nxt_vld;
            last_ff <= nxt_last;
            stat_ff <= nxt_stat;
        end
    end

    // Oscillator enable is a constant high register out of reset
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            osc_en_o <= 1'b1;
            conv_clk_ext_o <= 1'b0;
        end
        else
        begin
            osc_en_o <= 1'b1;
            conv_clk_ext_o <= ext_ff;
        end
    end

    assign main_result_o = main_word_ff;
    assign aux_result_o = aux_word_ff;
    assign link.sdata = sdata_ff;
    assign link.sdata_vld = vld_ff;
    assign link.sdata_last = last_ff;
    assign link.stat_byte = stat_ff;
endmodule : crb_dev_end

// ==== crb_host_end.sv ====
`timescale 1ns/1ps
// Host end: APB registers, issues reads, checks integrity, retries
module crb_host_end (
    input wire logic clk_i, // 10 MHz clock
    input wire logic nrst_i, // Sync reset, active low
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB enable
    input wire logic pwrite_i, // APB write
    input wire logic [7:0] paddr_i, // APB byte address
    input wire logic [31:0] pwdata_i, // APB write data
    output logic [31:0] prdata_o, // APB read data
    output logic pready_o, // APB ready
    output logic pslverr_o, // APB error, unmapped address
    crb_link_if.host link // Serial read-back link
);
    typedef enum logic [2:0] {
        CRH_IDLE = 3'b001,
        CRH_REQ = 3'b010,
        CRH_RECV = 3'b100
    } crb_host_state_t;

    crb_host_state_t st_ff;
    crb_host_state_t nxt_st;
    logic [1:0] kind_ff, nxt_kind;
    logic [1:0] mode_ff, nxt_mode;
    logic req_ff, nxt_req;
    logic [39:0] rx_ff, nxt_rx;
    logic [31:0] main_ff, nxt_main;
    logic [23:0] aux_ff, nxt_aux;
    logic [7:0] byte_ff, nxt_byte;
    logic [7:0] stat_ff, nxt_stat;
    logic [3:0] retry_ff, nxt_retry;
    logic err_ff, nxt_err;
    logic done_ff, nxt_done;
    logic [31:0] rdata_ff, nxt_rdata;
    logic ready_ff, nxt_ready;
    logic slverr_ff, nxt_slverr;
    logic setup;
    logic wr;
    logic [39:0] rx_n;
    logic chk_on;
    logic bad;

    assign setup = psel_i && !penable_i;
    assign wr = psel_i && penable_i && ready_ff && pwrite_i;
    assign rx_n = {rx_ff[38:0], link.sdata};
    assign chk_on = (mode_ff != crb_pkg::MODE_OFF) && (kind_ff != crb_pkg::KIND_REG);

    // Recompute integrity over the received data bytes
    always_comb
    begin
        bad = 1'b0;
        if (chk_on && kind_ff == crb_pkg::KIND_AUX)
        begin
            bad = crb_pkg::check_byte({8'h00, rx_n[31:8]}, 1'b1, mode_ff) != rx_n[7:0];
        end
        else if (chk_on)
        begin
            bad = crb_pkg::check_byte(rx_n[39:8], 1'b0, mode_ff) != rx_n[7:0];
        end
    end

    // Register bus and read sequencer
    always_comb
    begin
        nxt_st = st_ff;
        nxt_kind = kind_ff;
        nxt_mode = mode_ff;
        nxt_req = 1'b0;
        nxt_rx = rx_ff;
        nxt_main = main_ff;
        nxt_aux = aux_ff;
        nxt_byte = byte_ff;
        nxt_stat = stat_ff;
        nxt_retry = retry_ff;
        nxt_err = err_ff;
        nxt_done = done_ff;
        nxt_ready = setup;
        nxt_slverr = 1'b0;
        nxt_rdata = 32'h00000000;
        if (setup)
        begin
            unique case (paddr_i)
                crb_pkg::REG_CTRL: nxt_rdata = {26'h0, mode_ff, 1'b0, kind_ff, 1'b0};
                crb_pkg::REG_STATUS: nxt_rdata = {12'h0, retry_ff, stat_ff, 5'h0,
                                                  done_ff, err_ff, st_ff != CRH_IDLE};
                crb_pkg::REG_MAIN: nxt_rdata = main_ff;
                crb_pkg::REG_AUX: nxt_rdata = {8'h00, aux_ff};
                crb_pkg::REG_MAIN24: nxt_rdata = {8'h00, main_ff[31:8]};
                crb_pkg::REG_BYTE: nxt_rdata = {24'h0, byte_ff};
                default: nxt_slverr = 1'b1;
            endcase
        end
        if (wr && paddr_i == crb_pkg::REG_STATUS && pwdata_i[crb_pkg::STS_ERR])
        begin
            nxt_err = 1'b0;
        end
        unique case (st_ff)
            CRH_IDLE:
            begin
                if (wr && paddr_i == crb_pkg::REG_CTRL)
                begin
                    nxt_kind = pwdata_i[crb_pkg::CTRL_KIND +: 2];
                    nxt_mode = pwdata_i[crb_pkg::CTRL_MODE +: 2];
                    if (pwdata_i[crb_pkg::CTRL_START])
                    begin
                        nxt_st = CRH_REQ;
                        nxt_retry = 4'h0;
                        nxt_done = 1'b0;
                    end
                end
            end
            CRH_REQ:
            begin
                nxt_req = 1'b1;
                nxt_st = CRH_RECV;
            end
            CRH_RECV:
            begin
                if (link.sdata_vld)
                begin
                    nxt_rx = rx_n;
                end
                if (link.sdata_vld && link.sdata_last)
                begin
                    nxt_stat = link.stat_byte;
                    if (bad && retry_ff != crb_pkg::MAX_RETRY)
                    begin
                        nxt_retry = retry_ff + 4'h1;
                        nxt_st = CRH_REQ;
                    end
                    else
                    begin
                        nxt_err = nxt_err || bad; // Set wins over clear
                        nxt_done = 1'b1;
                        nxt_st = CRH_IDLE;
                        unique case (kind_ff)
                            crb_pkg::KIND_AUX: nxt_aux = chk_on ? rx_n[31:8] : rx_n[23:0];
                            crb_pkg::KIND_REG: nxt_byte = rx_n[7:0];
                            default: nxt_main = chk_on ? rx_n[39:8] : rx_n[31:0];
                        endcase
                        if (chk_on)
                        begin
                            nxt_byte = rx_n[7:0];
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            st_ff <= CRH_IDLE;
            kind_ff <= crb_pkg::KIND_MAIN;
            mode_ff <= crb_pkg::MODE_OFF;
            req_ff <= 1'b0;
            rx_ff <= 40'h0000000000;
            main_ff <= 32'h00000000;
            aux_ff <= 24'h000000;
            byte_ff <= 8'h00;
            stat_ff <= 8'h00;
            retry_ff <= 4'h0;
            err_ff <= 1'b0;
            done_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            ready_ff <= 1'b0;
            slverr_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            kind_ff <= nxt_kind;
            mode_ff <= nxt_mode;
            req_ff <= nxt_req;
            rx_ff <= nxt_rx;
            main_ff <= nxt_main;
            aux_ff <= nxt_aux;
            byte_ff <= nxt_byte;
            stat_ff <= nxt_stat;
            retry_ff <= nxt_retry;
            err_ff <= nxt_err;
            done_ff <= nxt_done;
            rdata_ff <= nxt_rdata;
            ready_ff <= nxt_ready;
            slverr_ff <= nxt_slverr;
        end
    end

    assign prdata_o = rdata_ff;
    assign pready_o = ready_ff;
    assign pslverr_o = slverr_ff;
    assign link.rd_req = req_ff;
    assign link.rd_kind = kind_ff;
    assign link.chk_mode = mode_ff;
endmodule : crb_host_end

// ==== crb_link_if.sv ====
`timescale 1ns/1ps
// Serial read-back link between device end and host end, one clock
interface crb_link_if;
    logic rd_req;
    logic [1:0] rd_kind;
    logic [1:0] chk_mode;
    logic sdata;
    logic sdata_vld;
    logic sdata_last;
    logic [7:0] stat_byte;

    modport dev (
        input rd_req, rd_kind, chk_mode,
        output sdata, sdata_vld, sdata_last, stat_byte
    );
    modport host (
        output rd_req, rd_kind, chk_mode,
        input sdata, sdata_vld, sdata_last, stat_byte
    );
endinterface : crb_link_if

// ==== crb_pkg.sv ====
package crb_pkg;
    // Read request kinds
    localparam logic [1:0] KIND_MAIN = 2'h0;
    localparam logic [1:0] KIND_AUX = 2'h1;
    localparam logic [1:0] KIND_REG = 2'h2;
    // Integrity byte modes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SUM = 2'h1;
    localparam logic [1:0] MODE_CRC = 2'h2;
    localparam logic [7:0] SUM_OFFSET = 8'h9B;
    localparam logic [7:0] CRC_POLY = 8'h07;
    // Clip limits
    localparam logic [31:0] MAIN_MAX = 32'h7FFFFFFF;
    localparam logic [31:0] MAIN_MIN = 32'h80000000;
    localparam logic [23:0] AUX_MAX = 24'h7FFFFF;
    localparam logic [23:0] AUX_MIN = 24'h800000;
    // Frame lengths in bits
    localparam logic [5:0] MAIN_BITS = 6'h20;
    localparam logic [5:0] AUX_BITS = 6'h18;
    localparam logic [5:0] REG_BITS = 6'h08;
    localparam logic [5:0] CHK_BITS = 6'h08;
    // Status byte fields
    localparam int STAT_AUX_NEW = 7;
    localparam int STAT_MAIN_NEW = 6;
    localparam int STAT_CLK_SRC = 5;
    // Clock activity window
    localparam int CLK_PERIOD_NS = 100;
    localparam int DET_WIN_NS = 2000;
    localparam logic [7:0] DET_WIN_CYC = 8'(DET_WIN_NS / CLK_PERIOD_NS);
    // Host register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MAIN = 8'h08;
    localparam logic [7:0] REG_AUX = 8'h0C;
    localparam logic [7:0] REG_MAIN24 = 8'h10;
    localparam logic [7:0] REG_BYTE = 8'h14;
    // Host register fields
    localparam int CTRL_START = 0;
    localparam int CTRL_KIND = 1;
    localparam int CTRL_MODE = 4;
    localparam int STS_BUSY = 0;
    localparam int STS_ERR = 1;
    localparam int STS_DONE = 2;
    localparam int STS_STAT = 8;
    localparam int STS_RETRY = 16;
    localparam logic [3:0] MAX_RETRY = 4'h3;

    // One byte into a CRC-8, MSB first; zero start equals zero-padded division
    function automatic logic [7:0] crc8_byte(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int k = 0; k < 8; k++)
        begin
            r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction : crc8_byte

    // Integrity byte over four main bytes, or three aux bytes in w[23:0]
    function automatic logic [7:0] check_byte(input logic [31:0] w, input logic aux,
                                              input logic [1:0] mode);
        logic [7:0] sum;
        logic [7:0] crc;
        sum = SUM_OFFSET;
        crc = 8'h00;
        for (int i = 0; i < 4; i++)
        begin
            if (!(aux && i == 0))
            begin
                sum = 8'(sum + w[31 - 8 * i -: 8]);
                crc = crc8_byte(crc, w[31 - 8 * i -: 8]);
            end
        end
        return (mode == MODE_CRC) ? crc : sum;
    endfunction : check_byte
endpackage : crb_pkg

// ==== crb_sva.sv ====
`timescale 1ns/1ps
// Link checker beside the interface joining the two ends
module crb_sva (
    input wire logic clk_i, // 10 MHz clock
    input wire logic nrst_i, // Sync reset, active low
    input wire logic rd_req, // Read request pulse
    input wire logic [1:0] rd_kind, // Request kind
    input wire logic [1:0] chk_mode, // Integrity mode
    input wire logic sdata, // Serial bit
    input wire logic sdata_vld, // Bit valid
    input wire logic sdata_last, // Final bit of frame
    input wire logic [7:0] stat_byte // Status byte
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    logic busy_ff;
    logic nxt_busy;
    logic [5:0] cnt_ff;
    logic [5:0] nxt_cnt;
    logic [5:0] len_ff;
    logic [5:0] nxt_len;
    // Expected frame length fixed at the taken request, as the device latches it
    always_comb
    begin
        nxt_busy = sdata_last ? 1'b0 : busy_ff;
        nxt_len = len_ff;
        nxt_cnt = sdata_last ? 6'h00 : cnt_ff + 6'(sdata_vld);
        if (rd_req && !busy_ff)
        begin
            nxt_busy = 1'b1;
            nxt_len = (rd_kind == crb_pkg::KIND_AUX) ? crb_pkg::AUX_BITS :
                (rd_kind == crb_pkg::KIND_REG) ? crb_pkg::REG_BITS : crb_pkg::MAIN_BITS;
            if (rd_kind != crb_pkg::KIND_REG && chk_mode != crb_pkg::MODE_OFF)
                nxt_len = nxt_len + crb_pkg::CHK_BITS;
        end
    end
    // Helper registers only
    always_ff @(posedge clk_i)
    begin
        busy_ff <= nrst_i ? nxt_busy : 1'b0;
        cnt_ff <= nrst_i ? nxt_cnt : 6'h00;
        len_ff <= nrst_i ? nxt_len : 6'h00;
    end
    property p_len; sdata_last |-> (cnt_ff + 6'h01 == len_ff); endproperty
    a_len: assert property (p_len) else $error("frame length wrong");
    property p_start; $rose(sdata_vld) |-> $past(rd_req, 2); endproperty
    a_start: assert property (p_start) else $error("frame without request");
    property p_resp; rd_req && !busy_ff |-> ##2 sdata_vld; endproperty
    a_resp: assert property (p_resp) else $error("no answer to request");
    property p_cont; sdata_vld && !sdata_last |=> sdata_vld; endproperty
    a_cont: assert property (p_cont) else $error("gap inside frame");
    property p_lastvld; sdata_last |-> sdata_vld; endproperty
    a_lastvld: assert property (p_lastvld) else $error("last without valid");
    property p_gap; sdata_last |=> !sdata_vld; endproperty
    a_gap: assert property (p_gap) else $error("bits after last");
    property p_idle; !busy_ff |-> !sdata_vld; endproperty
    a_idle: assert property (p_idle) else $error("bit outside frame");
    property p_bound; $rose(sdata_vld) |-> ##[7:39] sdata_last; endproperty
    a_bound: assert property (p_bound) else $error("frame never ends");
    property p_stat; stat_byte[4:0] == 5'h00; endproperty
    a_stat: assert property (p_stat) else $error("status spare bits set");
endmodule : crb_sva

// ==== tb_top.sv ====
`timescale 1ns/1ps
// Both ends joined; APB drives the host end, converter inputs the device end
module tb_top;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic [31:0] r;
    logic pready_o, pslverr_o, e, osc_en_o, conv_clk_ext_o;
    logic [33:0] main_raw_i = 34'h0;
    logic [25:0] aux_raw_i = 26'h0;
    logic main_done_i = 1'b0;
    logic aux_done_i = 1'b0;
    logic clock_input_pin_i = 1'b0;
    logic [7:0] reg_byte_i = 8'hA5;
    logic [31:0] main_result_o;
    logic [23:0] aux_result_o;
    logic [63:0] shreg = 64'h0;
    int nbits = 0;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    // Raw inputs, the two beyond range exercise clipping
    logic [33:0] mr [4] = '{34'h012345678, 34'h100000000, 34'h200000000, 34'h0};
    logic [31:0] me [4] = '{32'h12345678, 32'h7FFFFFFF, 32'h80000000, 32'h0};
    logic [25:0] ar [4] = '{26'h0123456, 26'h1000000, 26'h2000000, 26'h0};
    logic [23:0] ae [4] = '{24'h123456, 24'h7FFFFF, 24'h800000, 24'h0};
    crb_link_if link ();
    crb_dev_end crb_dev_end_inst (.clk_i(clk_i), .nrst_i(nrst_i), .link(link),
        .main_raw_i(main_raw_i), .main_done_i(main_done_i), .aux_raw_i(aux_raw_i),
        .aux_done_i(aux_done_i), .reg_byte_i(reg_byte_i),
        .clock_input_pin_i(clock_input_pin_i), .osc_en_o(osc_en_o),
        .conv_clk_ext_o(conv_clk_ext_o), .main_result_o(main_result_o),
        .aux_result_o(aux_result_o));
    crb_host_end crb_host_end_inst (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .link(link));
    crb_sva crb_sva_inst (.clk_i(clk_i), .nrst_i(nrst_i), .rd_req(link.rd_req),
        .rd_kind(link.rd_kind), .chk_mode(link.chk_mode), .sdata(link.sdata),
        .sdata_vld(link.sdata_vld), .sdata_last(link.sdata_last), .stat_byte(link.stat_byte));
    initial
    begin
        forever #50 clk_i = ~clk_i;
    end
    task results;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    // Collects wire bits and cuts a hang short
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            results();
        end
        if (link.sdata_vld === 1'b1)
        begin
            shreg <= {shreg[62:0], link.sdata};
            nbits <= nbits + 1;
        end
    end
    task chk(input string nm, input logic [63:0] x, input logic [63:0] g);
        n_checks++;
        if (g !== x)
        begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", nm, x, g);
        end
    endtask : chk
    // One APB transfer; waits on pready, bounded only by the cycle ceiling
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task conv(input logic [33:0] m, input logic [25:0] a);
        @(posedge clk_i);
        main_raw_i <= m;
        aux_raw_i <= a;
        main_done_i <= 1'b1;
        aux_done_i <= 1'b1;
        @(posedge clk_i);
        main_done_i <= 1'b0;
        aux_done_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : conv
    // Integrity byte: byte sum plus 9Bh, or CRC by plain long division of the zero-padded word
    function automatic logic [7:0] exp_chk(input logic [31:0] w, input int nb,
                                           input logic [1:0] m);
        logic [7:0] s;
        logic [39:0] d;
        s = 8'h9B;
        d = (nb == 3) ? {8'h00, w[23:0], 8'h00} : {w, 8'h00};
        for (int i = 0; i < nb; i++)
            s = s + w[8 * i +: 8];
        for (int i = 39; i >= 8; i--)
            if (d[i])
                d[i -: 9] = d[i -: 9] ^ 9'h107;
        return (m == crb_pkg::MODE_CRC) ? d[7:0] : s;
    endfunction : exp_chk
    task run(input logic [1:0] k, input logic [1:0] m, input logic [31:0] w);
        int nb;
        int n;
        logic [63:0] x;
        nb = (k == crb_pkg::KIND_MAIN) ? 4 : (k == crb_pkg::KIND_AUX) ? 3 : 1;
        x = 64'(w);
        n = nb * 8;
        if (m != crb_pkg::MODE_OFF && k != crb_pkg::KIND_REG)
        begin
            x = {x[55:0], exp_chk(w, nb, m)};
            n = n + 8;
        end
        nbits = 0;
        shreg = 64'h0;
        apb(1'b1, crb_pkg::REG_CTRL, (32'(m) << 4) | (32'(k) << 1) | 32'h1);
        do apb(1'b0, crb_pkg::REG_STATUS, 32'h0); while (r[0] !== 1'b0 || nbits < n);
        chk("sts", 64'h4, 64'({r[19:16], r[2:0]}));
        chk("bits", 64'(n), 64'(nbits));
        chk("frame", x, shreg);
        apb(1'b0, crb_pkg::REG_BYTE, 32'h0);
        if (m != crb_pkg::MODE_OFF || k == crb_pkg::KIND_REG)
            chk("byte", 64'(x[7:0]), 64'(r[7:0]));
        if (k != crb_pkg::KIND_REG)
            chk("new_clr", 64'h0, 64'(link.stat_byte[6 + k]));
    endtask : run
    initial
    begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        chk("osc", 64'h1, 64'(osc_en_o));
        chk("stat0", 64'h0, 64'(link.stat_byte));
        apb(1'b0, crb_pkg::REG_MAIN, 32'h0);
        chk("main0", 64'h0, 64'(r));
        apb(1'b0, 8'h3C, 32'h0);
        chk("unmapped", 64'h1, 64'({r, e}));
        for (int t = 0; t < 4; t++)
        begin
            conv(mr[t], ar[t]);
            chk("new", 64'h3, 64'(link.stat_byte[7:6]));
            chk("mres", 64'(me[t]), 64'(main_result_o));
            chk("ares", 64'(ae[t]), 64'(aux_result_o));
            for (int k = 0; k < 3; k++)
                for (int m = 0; m < 3; m++)
                    run(2'(k), 2'(m), (k == 0) ? me[t] : (k == 1) ? 32'(ae[t]) : 32'(reg_byte_i));
            apb(1'b0, crb_pkg::REG_MAIN24, 32'h0);
            chk("main24", 64'(me[t] >> 8), 64'(r));
        end
        // External clock toggling then stopping
        repeat (10)
        begin
            @(posedge clk_i);
            clock_input_pin_i <= ~clock_input_pin_i;
        end
        repeat (5) @(posedge clk_i);
        chk("ext", 64'h1, 64'(link.stat_byte[5]));
        chk("ext_clk", 64'h1, 64'(conv_clk_ext_o));
        repeat (30) @(posedge clk_i);
        chk("int", 64'h0, 64'({link.stat_byte[5], conv_clk_ext_o}));
        results();
    end
endmodule : tb_top
